// >>> test/sbsis_link_assertions.sv
// Checker watching the shared link between the master and slave ends
module sbsis_link_assertions (
    input wire logic                              sys_clk,
    input wire logic                              sys_rst,
    input wire logic                              bus_clk,
    input wire logic [sbsis_pkg::BUS_ADDR_W-1:0]  bus_addr,
    input wire logic                              bus_direction,
    input wire logic [sbsis_pkg::BUS_DATA_W-1:0]  m_data_out,
    input wire logic                              m_data_oe,
    input wire logic [sbsis_pkg::BUS_DATA_W-1:0]  s_data_out,
    input wire logic                              s_data_oe,
    input wire logic [sbsis_pkg::CFG_W-1:0]       input_source_config_reg,
    input wire logic [sbsis_pkg::BUS_ADDR_W-1:0]  slave_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    import sbsis_pkg::*;

    logic rd_hit;

    // Addressed read while connected; reads of the broadcast address are not counted, though the slave answers them if its own address is BUS_ADDR_BCAST
    assign rd_hit = input_source_config_reg[CFG_BUS_SEL_POS] && bus_direction == BUS_DIR_READ
                    && bus_addr == slave_addr && bus_addr != BUS_ADDR_BCAST;

    sequence s_read_cmd;
        rd_hit;
    endsequence

    // Quiet for two periods, then exactly one period of drive
    sequence s_answer;
        !s_data_oe [*2] ##1 s_data_oe ##1 !s_data_oe;
    endsequence

    a_read_latency: assert property (@(posedge bus_clk) disable iff (sys_rst)
        s_read_cmd |-> ##1 s_answer) else $error("read answer not two periods late");

    a_drive_cause: assert property (@(posedge bus_clk) disable iff (sys_rst)
        s_data_oe |-> $past(rd_hit, 3)) else $error("slave drove without own read");

    a_no_fight: assert property (@(posedge bus_clk) disable iff (sys_rst)
        s_data_oe |-> !m_data_oe) else $error("both ends drive the data lines");

    a_master_release: assert property (@(posedge bus_clk) disable iff (sys_rst)
        bus_direction == BUS_DIR_READ |-> !m_data_oe) else $error("master drives on read");

    a_write_drive: assert property (@(posedge bus_clk) disable iff (sys_rst)
        bus_direction == BUS_DIR_WRITE |-> m_data_oe) else $error("master idle on write");

    a_write_upper: assert property (@(posedge bus_clk) disable iff (sys_rst)
        m_data_oe |-> m_data_out[15:2] == 14'h0000) else $error("write upper bits not zero");

    a_answer_upper: assert property (@(posedge bus_clk) disable iff (sys_rst)
        s_data_oe |-> s_data_out[15:1] == 15'h0000) else $error("answer upper bits not zero");

    // Master moves address and direction on falls only, so rises see them steady
    a_addr_stable: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(bus_clk) |-> $stable(bus_addr) && $stable(bus_direction))
        else $error("address or direction moved at a link rise");

    a_clk_period: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(bus_clk) |-> bus_clk [*4] ##1 !bus_clk [*4] ##1 bus_clk)
        else $error("link clock period wrong");

endmodule // sbsis_link_assertions

// >>> test/test_shared_bus_stream_input_slave.sv
// Self-checking bench: master and slave ends joined over the shared link
module test_shared_bus_stream_input_slave;
    timeunit 1ns;
    timeprecision 1ps;
    import sbsis_pkg::*;

    localparam logic [BUS_ADDR_W-1:0] OWN_ADDR = 4'h3;

    logic                  sys_clk       = 1'b0;
    logic                  sys_rst       = 1'b1;
    logic                  cmd_valid     = 1'b0;
    logic                  cmd_write     = 1'b1;
    logic [BUS_ADDR_W-1:0] cmd_addr      = 4'hf;
    logic                  cmd_bit_valid = 1'b0;
    logic                  cmd_bit       = 1'b0;
    logic [CFG_W-1:0]      cfg           = 8'h10;
    logic                  stream_ready  = 1'b1;
    logic                  cmd_ready;
    logic                  rsp_valid;
    logic                  rsp_req;
    logic                  stream_valid;
    logic                  stream_bit;
    logic                  stream_overrun;
    int                    fail_count    = 0;
    int                    checked       = 0;
    logic                  exp_bits[$];
    logic                  exp_req[$];

    sbsis_link_if link ();

    sbsis_master u_sbsis_master (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_bit_valid(cmd_bit_valid), .cmd_bit(cmd_bit),
        .rsp_valid(rsp_valid), .rsp_req(rsp_req));

    sbsis_slave u_sbsis_slave (.link(link), .sys_clk(sys_clk), .sys_rst(sys_rst),
        .input_source_config_reg(cfg), .slave_addr(OWN_ADDR), .stream_valid(stream_valid),
        .stream_bit(stream_bit), .stream_ready(stream_ready), .stream_overrun(stream_overrun));

    sbsis_link_assertions u_sbsis_link_assertions (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .bus_clk(link.bus_clk), .bus_addr(link.bus_addr), .bus_direction(link.bus_direction),
        .m_data_out(link.m_data_out), .m_data_oe(link.m_data_oe), .s_data_out(link.s_data_out),
        .s_data_oe(link.s_data_oe), .input_source_config_reg(cfg), .slave_addr(OWN_ADDR));

    // 100 MHz system clock
    always #5 sys_clk = ~sys_clk;

    task automatic compare_bit(input logic act, input logic exp, input string what);
        checked++;
        if (act !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t %s got %b want %b", $time, what, act, exp);
        end
    endtask

    task automatic summarize();
        if (fail_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Hold the command until a mid-cycle look sees it taken at the next edge
    task automatic send(input logic wr, input logic [BUS_ADDR_W-1:0] a, input logic v);
        int n;
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_addr <= a;
        cmd_bit_valid <= v;
        cmd_bit <= 1'($urandom);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 200);
        compare_bit(cmd_ready, 1'b1, "command not taken");
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
    endtask

    // Write one bit; note it when delivery is due
    task automatic put_bit(input logic [BUS_ADDR_W-1:0] a, input logic v, input logic due);
        send(1'b1, a, v);
        if (due) begin
            exp_bits.push_back(cmd_bit);
        end
        repeat (40) @(posedge sys_clk);
    endtask

    task automatic read_req(input logic exp);
        exp_req.push_back(exp);
        send(1'b0, OWN_ADDR, 1'b0);
        repeat (60) @(posedge sys_clk);
    endtask

    // Each delivered bit or read flag retires the oldest note
    always @(negedge sys_clk) begin
        if (!sys_rst && stream_valid === 1'b1 && stream_ready === 1'b1) begin
            if (exp_bits.size() == 0) begin
                compare_bit(1'b1, 1'b0, "unexpected bit");
            end else begin
                compare_bit(stream_bit, exp_bits.pop_front(), "stream bit");
            end
        end
        if (!sys_rst && rsp_valid === 1'b1) begin
            if (exp_req.size() == 0) begin
                compare_bit(1'b1, 1'b0, "unexpected answer");
            end else begin
                compare_bit(rsp_req, exp_req.pop_front(), "request flag");
            end
        end
    end

    // Hang guard, far above the expected run length
    initial begin
        #200us;
        fail_count++;
        summarize();
    end

    initial begin
        void'($urandom(36));
        // Five cycles of reset; the slave's link side finishes its own reset later
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (100) @(posedge sys_clk);
        for (int i = 0; i < 12; i++) begin
            case (i % 4)
                0: put_bit(OWN_ADDR, 1'b1, 1'b1);
                1: put_bit(BUS_ADDR_BCAST, 1'b1, 1'b1);
                2: put_bit(4'($urandom_range(14, 4)), 1'b1, 1'b0);
                default: put_bit(OWN_ADDR, 1'b0, 1'b0);
            endcase
        end
        read_req(1'b1);
        // Stalled consumer: flag drops, a second bit is lost and flagged
        @(posedge sys_clk);
        stream_ready <= 1'b0;
        put_bit(OWN_ADDR, 1'b1, 1'b1);
        read_req(1'b0);
        put_bit(OWN_ADDR, 1'b1, 1'b0);
        compare_bit(stream_overrun, 1'b1, "overrun");
        @(posedge sys_clk);
        stream_ready <= 1'b1;
        repeat (40) @(posedge sys_clk);
        read_req(1'b1);
        // Disconnected: every other config bit set, all traffic ignored
        @(posedge sys_clk);
        cfg <= 8'hef;
        repeat (60) @(posedge sys_clk);
        put_bit(OWN_ADDR, 1'b1, 1'b0);
        put_bit(BUS_ADDR_BCAST, 1'b1, 1'b0);
        read_req(1'b0);
        @(posedge sys_clk);
        cfg <= 8'h10;
        repeat (60) @(posedge sys_clk);
        put_bit(OWN_ADDR, 1'b1, 1'b1);
        repeat (60) @(posedge sys_clk);
        compare_bit(exp_bits.size() == 0 && exp_req.size() == 0, 1'b1, "results missing");
        summarize();
    end

endmodule // test_shared_bus_stream_input_slave

// >>> verilog/sbsis_link_if.sv
// Shared synchronous data bus joining one master and one slave
interface sbsis_link_if;
    import sbsis_pkg::*;

    logic                  bus_clk;
    logic [BUS_ADDR_W-1:0] bus_addr;
    logic                  bus_direction;
    logic [BUS_DATA_W-1:0] m_data_out;
    logic                  m_data_oe;
    logic [BUS_DATA_W-1:0] s_data_out;
    logic                  s_data_oe;
    logic [BUS_DATA_W-1:0] bus_data;

    // Wire level from the two enables; a fight shows as unknown
    // Released lines rest low, as if pulled down
    assign bus_data = (m_data_oe && s_data_oe) ? 16'hxxxx :
                      m_data_oe ? m_data_out :
                      s_data_oe ? s_data_out : 16'h0000;

    modport master (
        output bus_clk,
        output bus_addr,
        output bus_direction,
        output m_data_out,
        output m_data_oe,
        input  bus_data
    );

    modport slave (
        input  bus_clk,
        input  bus_addr,
        input  bus_direction,
        output s_data_out,
        output s_data_oe,
        input  bus_data
    );

endinterface : sbsis_link_if

// >>> verilog/sbsis_master.sv
// Bus master end: derives the link clock and runs write and read cycles
module sbsis_master (
    input  wire logic                           sys_clk,
    input  wire logic                           sys_rst,
    sbsis_link_if.master                        link,
    input  wire logic                           cmd_valid,
    output logic                                cmd_ready,
    input  wire logic                           cmd_write,
    input  wire logic [sbsis_pkg::BUS_ADDR_W-1:0] cmd_addr,
    input  wire logic                           cmd_bit_valid,
    input  wire logic                           cmd_bit,
    output logic                                rsp_valid,
    output logic                                rsp_req
);
    import sbsis_pkg::*;

    logic [BUS_HALF_CNT_W-1:0] half_cnt_r;
    logic                      clk_r;
    logic                      rise_ev;
    logic                      fall_ev;
    sbsis_mstate_t             state_r;
    logic [1:0]                wait_r;
    logic [BUS_ADDR_W-1:0]     addr_r;
    logic                      dir_r;
    logic [BUS_DATA_W-1:0]     dout_r;
    logic                      oe_r;
    logic                      din_s1_r;
    logic                      din_s2_r;
    logic                      rsp_valid_r;
    logic                      rsp_req_r;

    // Link clock divider; outputs change on its falling edge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            half_cnt_r <= '0;
            clk_r      <= 1'b0;
        end else begin
            half_cnt_r <= half_cnt_r + 2'h1;
            if (half_cnt_r == BUS_HALF_LAST) begin
                clk_r <= ~clk_r;
            end
        end
    end

    assign rise_ev = (half_cnt_r == BUS_HALF_LAST) && !clk_r;
    assign fall_ev = (half_cnt_r == BUS_HALF_LAST) && clk_r;

    // Answer bit is driven by the slave, so it passes two flops first
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            din_s1_r <= 1'b0;
            din_s2_r <= 1'b0;
        end else begin
            din_s1_r <= link.bus_data[DATA_REQ_POS];
            din_s2_r <= din_s1_r;
        end
    end

    // Commands are taken only while idle, on a falling edge
    assign cmd_ready = (state_r == SBSIS_M_IDLE) && fall_ev;

    // Sequencer; idle is a broadcast write with no valid bit
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r <= SBSIS_M_IDLE;
            wait_r  <= WAIT_RST;
            addr_r  <= BUS_ADDR_BCAST;
            dir_r   <= BUS_DIR_WRITE;
            dout_r  <= BUS_DATA_RST;
            oe_r    <= 1'b1;
        end else if (fall_ev) begin
            unique case (state_r)
                SBSIS_M_IDLE: begin
                    if (cmd_valid) begin
                        addr_r <= cmd_addr;
                        if (cmd_write) begin
                            dir_r  <= BUS_DIR_WRITE;
                            oe_r   <= 1'b1;
                            dout_r <= BUS_DATA_RST;
                            dout_r[DATA_VALID_POS] <= cmd_bit_valid;
                            dout_r[DATA_BIT_POS]   <= cmd_bit;
                            state_r <= SBSIS_M_WRITE;
                        end else begin
                            dir_r   <= BUS_DIR_READ;
                            oe_r    <= 1'b0;
                            state_r <= SBSIS_M_READ;
                        end
                    end
                end
                SBSIS_M_WRITE: begin
                    addr_r  <= BUS_ADDR_BCAST;
                    dout_r  <= BUS_DATA_RST;
                    state_r <= SBSIS_M_IDLE;
                end
                SBSIS_M_READ: begin
                    // Park on a read of the broadcast address, lines released
                    addr_r  <= BUS_ADDR_BCAST;
                    wait_r  <= WAIT_RST;
                    state_r <= SBSIS_M_WAIT;
                end
                SBSIS_M_WAIT: begin
                    wait_r <= wait_r + 2'h1;
                    if (wait_r == WAIT_RELEASE) begin
                        dir_r   <= BUS_DIR_WRITE;
                        dout_r  <= BUS_DATA_RST;
                        oe_r    <= 1'b1;
                        state_r <= SBSIS_M_IDLE;
                    end
                end
            endcase
        end
    end

    // Flow-control flag taken mid-period after the slave's answer edge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rsp_valid_r <= 1'b0;
            rsp_req_r   <= 1'b0;
        end else begin
            rsp_valid_r <= fall_ev && (state_r == SBSIS_M_WAIT) && (wait_r == WAIT_SAMPLE);
            if (fall_ev && (state_r == SBSIS_M_WAIT) && (wait_r == WAIT_SAMPLE)) begin
                rsp_req_r <= din_s2_r;
            end
        end
    end

    assign link.bus_clk       = clk_r;
    assign link.bus_addr      = addr_r;
    assign link.bus_direction = dir_r;
    assign link.m_data_out    = dout_r;
    assign link.m_data_oe     = oe_r;
    assign rsp_valid          = rsp_valid_r;
    assign rsp_req            = rsp_req_r;

endmodule // sbsis_master

// >>> verilog/sbsis_pkg.sv
// Shared constants for the shared-bus stream input link
package sbsis_pkg;

    // Link widths
    localparam int unsigned BUS_ADDR_W = 4;
    localparam int unsigned BUS_DATA_W = 16;

    // Address that every receiving slave treats as its own on writes
    localparam logic [BUS_ADDR_W-1:0] BUS_ADDR_BCAST = 4'hf;

    // Direction encoding, seen from the master
    localparam logic BUS_DIR_READ  = 1'h1;
    localparam logic BUS_DIR_WRITE = 1'h0;

    // Field positions on the data lines
    localparam int unsigned DATA_VALID_POS = 0;
    localparam int unsigned DATA_BIT_POS   = 1;
    localparam int unsigned DATA_REQ_POS   = 0;

    // Configuration byte and its bus-connection select bit
    localparam int unsigned CFG_W           = 8;
    localparam int unsigned CFG_BUS_SEL_POS = 4;

    // Read answer latency in link clock periods
    localparam int unsigned READ_LATENCY = 2;

    // Link clock derived by the master: half period in sys_clk cycles
    localparam int unsigned SYS_CLK_MHZ    = 100;
    localparam int unsigned BUS_CLK_HALF   = 4;
    localparam int unsigned BUS_HALF_CNT_W = 2;
    localparam logic [BUS_HALF_CNT_W-1:0] BUS_HALF_LAST = 2'h3;

    // Values after reset
    localparam logic [BUS_DATA_W-1:0] BUS_DATA_RST = 16'h0000;
    localparam logic [1:0]            WAIT_RST     = 2'h0;

    // Master wait counts, in link clock falling edges after the read
    localparam logic [1:0] WAIT_SAMPLE  = 2'h1;
    localparam logic [1:0] WAIT_RELEASE = 2'h2;

    // Master sequencer states
    typedef enum logic [1:0] {
        SBSIS_M_IDLE  = 2'b00,
        SBSIS_M_WRITE = 2'b01,
        SBSIS_M_READ  = 2'b10,
        SBSIS_M_WAIT  = 2'b11
    } sbsis_mstate_t;

endpackage : sbsis_pkg

// >>> verilog/sbsis_slave.sv
// Modulator input port: slave end of the shared bus, bits out to sys_clk
module sbsis_slave (
    sbsis_link_if.slave                         link,
    input  wire logic                           sys_clk,
    input  wire logic                           sys_rst,
    input  wire logic [sbsis_pkg::CFG_W-1:0]    input_source_config_reg,
    input  wire logic [sbsis_pkg::BUS_ADDR_W-1:0] slave_addr,
    output logic                                stream_valid,
    output logic                                stream_bit,
    input  wire logic                           stream_ready,
    output logic                                stream_overrun
);
    import sbsis_pkg::*;

    // ---- link clock domain ----
    logic                  lrst_s1_r;
    logic                  lrst_s2_r;
    logic                  cfg_s1_r;
    logic                  cfg_s2_r;
    logic [BUS_ADDR_W-1:0] my_s1_r;
    logic [BUS_ADDR_W-1:0] my_s2_r;
    logic                  ack_s1_r;
    logic                  ack_s2_r;
    logic                  wr_hit;
    logic                  rd_hit;
    logic                  busy;
    logic                  req_tgl_r;
    logic                  hold_bit_r;
    logic                  ovr_r;
    logic                  rd_p1_r;
    logic                  rd_p2_r;
    logic                  flag_p1_r;
    logic                  flag_p2_r;
    logic                  oe_r;
    logic [BUS_DATA_W-1:0] dout_r;

    // ---- sys_clk domain ----
    logic                  lrst_req_r;
    logic                  lack_s1_r;
    logic                  lack_s2_r;
    logic                  req_s1_r;
    logic                  req_s2_r;
    logic                  req_s3_r;
    logic                  ovr_s1_r;
    logic                  ovr_s2_r;
    logic                  ack_tgl_r;
    logic                  valid_r;
    logic                  bit_r;

    // Link-side reset request; the master stops the link clock in reset,
    // so the request stands until the link side shows that it took it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            lrst_req_r <= 1'b1;
            lack_s1_r  <= 1'b0;
            lack_s2_r  <= 1'b0;
        end else begin
            lack_s1_r <= lrst_s2_r;
            lack_s2_r <= lack_s1_r;
            if (lack_s2_r) begin
                lrst_req_r <= 1'b0;
            end
        end
    end

    // Reset request carried into the link domain, two flops
    always_ff @(posedge link.bus_clk) begin
        lrst_s1_r <= lrst_req_r;
        lrst_s2_r <= lrst_s1_r;
    end

    // Static settings from the sys_clk side, two flops each
    always_ff @(posedge link.bus_clk) begin
        if (lrst_s2_r) begin
            cfg_s1_r <= 1'b0;
            cfg_s2_r <= 1'b0;
            my_s1_r  <= '0;
            my_s2_r  <= '0;
        end else begin
            cfg_s1_r <= input_source_config_reg[CFG_BUS_SEL_POS];
            cfg_s2_r <= cfg_s1_r;
            my_s1_r  <= slave_addr;
            my_s2_r  <= my_s1_r;
        end
    end

    // Handshake return from the sys_clk side
    always_ff @(posedge link.bus_clk) begin
        if (lrst_s2_r) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            ack_s1_r <= ack_tgl_r;
            ack_s2_r <= ack_s1_r;
        end
    end

    // A bit is in flight until the far side echoes the toggle
    assign busy = req_tgl_r ^ ack_s2_r;

    // Transaction decode; bits 15:2 of a write are never looked at
    assign wr_hit = cfg_s2_r
                    && (link.bus_direction == BUS_DIR_WRITE)
                    && ((link.bus_addr == my_s2_r)
                        || (link.bus_addr == BUS_ADDR_BCAST))
                    && link.bus_data[DATA_VALID_POS];
    assign rd_hit = cfg_s2_r
                    && (link.bus_direction == BUS_DIR_READ)
                    && (link.bus_addr == my_s2_r);

    // Capture a valid stream bit on the rising edge
    always_ff @(posedge link.bus_clk) begin
        if (lrst_s2_r) begin
            req_tgl_r  <= 1'b0;
            hold_bit_r <= 1'b0;
        end else if (wr_hit && !busy) begin
            hold_bit_r <= link.bus_data[DATA_BIT_POS];
            req_tgl_r  <= ~req_tgl_r;
        end
    end

    // Sticky overrun: a master that ignores the flag loses bits here
    always_ff @(posedge link.bus_clk) begin
        if (lrst_s2_r) begin
            ovr_r <= 1'b0;
        end else if (wr_hit && busy) begin
            ovr_r <= 1'b1;
        end
    end

    // Read pipeline: command edge, one period, then drive
    always_ff @(posedge link.bus_clk) begin
        if (lrst_s2_r) begin
            rd_p1_r   <= 1'b0;
            rd_p2_r   <= 1'b0;
            flag_p1_r <= 1'b0;
            flag_p2_r <= 1'b0;
        end else begin
            rd_p1_r   <= rd_hit;
            rd_p2_r   <= rd_p1_r;
            flag_p1_r <= !busy;
            flag_p2_r <= flag_p1_r;
        end
    end

    // Data lines driven for one period only, answer in bit zero
    always_ff @(posedge link.bus_clk) begin
        if (lrst_s2_r) begin
            oe_r   <= 1'b0;
            dout_r <= BUS_DATA_RST;
        end else begin
            oe_r   <= rd_p2_r && cfg_s2_r;
            dout_r <= BUS_DATA_RST;
            // Flag sampled at the command edge; bits 15:1 stay zero
            dout_r[DATA_REQ_POS] <= rd_p2_r && flag_p2_r;
        end
    end

    assign link.s_data_out = dout_r;
    assign link.s_data_oe  = oe_r;

    // Toggle and overrun level into sys_clk; stage one feeds stage two only
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
            ovr_s1_r <= 1'b0;
            ovr_s2_r <= 1'b0;
        end else begin
            req_s1_r <= req_tgl_r;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
            ovr_s1_r <= ovr_r;
            ovr_s2_r <= ovr_s1_r;
        end
    end

    // Offer each bit to the user; echo the toggle once it is taken
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            valid_r   <= 1'b0;
            bit_r     <= 1'b0;
            ack_tgl_r <= 1'b0;
        end else if (req_s2_r != req_s3_r) begin
            // Held bit is stable while the toggles differ
            valid_r <= 1'b1;
            bit_r   <= hold_bit_r;
        end else if (valid_r && stream_ready) begin
            valid_r   <= 1'b0;
            ack_tgl_r <= req_s3_r;
        end
    end

    assign stream_valid   = valid_r;
    assign stream_bit     = bit_r;
    assign stream_overrun = ovr_s2_r;

endmodule // sbsis_slave
